// ==== rtl/psx_baud_div.sv ====
/*
  baud pre-divider: divide by 13 or 12, then by 16.
  assumes the select comes from logic on the same clock.
*/
`timescale 1ns/1ps
module psx_baud_div (
  input wire logic clk,
  input wire logic sys_rst,
  psx_div_if.div port
);
  import psx_pkg::*;

  logic [3:0] baseCnt_reg, baseCnt_next; // first stage count
  logic [3:0] refCnt_reg, refCnt_next; // second stage count
  logic baseTick_reg, baseTick_next;
  logic refTick_reg, refTick_next;
  logic [3:0] limit;

  // divisor chosen live; a change mid-period already moves the wrap of the current period
  always_comb begin
    limit = port.divideBy12 ? DIV_MIDI : DIV_NORMAL;
    baseTick_next = 1'b0;
    refTick_next = 1'b0;
    refCnt_next = refCnt_reg;
    if (baseCnt_reg >= limit - 4'h1) begin
      // >= so a shrinking divisor never overruns
      baseCnt_next = 4'h0;
      baseTick_next = 1'b1;
      refCnt_next = refCnt_reg + 4'h1;
      refTick_next = (refCnt_reg == REF_LAST);
    end else begin
      baseCnt_next = baseCnt_reg + 4'h1;
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      baseCnt_reg <= 4'h0;
      refCnt_reg <= 4'h0;
      baseTick_reg <= 1'b0;
      refTick_reg <= 1'b0;
    end else begin
      baseCnt_reg <= baseCnt_next;
      refCnt_reg <= refCnt_next;
      baseTick_reg <= baseTick_next;
      refTick_reg <= refTick_next;
    end
  end

  assign port.baseTick = baseTick_reg;
  assign port.refTick = refTick_reg;

  // helper: cycles between ticks, and whether select moved meanwhile
  logic [4:0] gapCnt;
  logic hadTick;
  logic selMoved;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gapCnt <= 5'h01;
      hadTick <= 1'b0;
      selMoved <= 1'b0;
    end else begin
      gapCnt <= baseTick_reg ? 5'h01 : gapCnt + 5'h01;
      hadTick <= hadTick | baseTick_reg;
      selMoved <= baseTick_reg ? 1'b0 : (selMoved | (port.divideBy12 != $past(port.divideBy12)));
    end
  end

  AST_DIV_MIDI: assert property (@(posedge clk) disable iff (sys_rst)
    baseTick_reg && hadTick && !selMoved && port.divideBy12 && $stable(port.divideBy12) |-> gapCnt == 5'd12)
    else $error("MIDI divider period is not 12");
  AST_DIV_NORMAL: assert property (@(posedge clk) disable iff (sys_rst)
    baseTick_reg && hadTick && !selMoved && !port.divideBy12 && $stable(port.divideBy12) |-> gapCnt == 5'd13)
    else $error("normal divider period is not 13");
  AST_REF_WITH_BASE: assert property (@(posedge clk) disable iff (sys_rst)
    refTick_reg |-> baseTick_reg ##1 !baseTick_reg [*8])
    else $error("reference tick not aligned with base tick");
  COV_REF_TICK: cover property (@(posedge clk) disable iff (sys_rst) refTick_reg && port.divideBy12);
endmodule : psx_baud_div

// ==== rtl/psx_div_if.sv ====
/*
  link between the setup register and one baud divider.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface psx_div_if;
  logic divideBy12; // MIDI select
  logic baseTick; // one pulse per divisor period
  logic refTick; // one pulse per sixteen base ticks
  modport ctrl (output divideBy12, input baseTick, input refTick);
  modport div (input divideBy12, output baseTick, output refTick);
endinterface : psx_div_if

// ==== rtl/psx_pkg.sv ====
/*
  constants, types and one decode function for the parallel/serial
  extended setup register block.
  assumes a single 200 MHz device clock and a synchronous reset.
*/
// Notes on behaviour
// - override low: decode two-bit parallel mode field
// - mode field defaults to standard/bidirectional
// - floppy field: normal, option one, two
// - first uart: divide 13, MIDI 12
// - second uart: divide 13, MIDI 12
// - EPP type bit picks revision 1.9/1.7
// - ECP+EPP with ecr 100 gives EPP
// - either ECP mode, ecr 000 gives SPP
// - ECP modes: only two drives directly
// - MIDI: divide 12 then 16 reference
// - config mode, index 04H; reset 00H
package psx_pkg;
  // register access
  localparam logic [7:0] SETUP_INDEX = 8'h04; // index selecting this register
  localparam logic [7:0] SETUP_RESET = 8'h00; // power-up value
  // field positions
  localparam int MODE_LSB = 0;
  localparam int FLOPPY_LSB = 2;
  localparam int MIDI1_BIT = 4;
  localparam int MIDI2_BIT = 5;
  localparam int EPPTYPE_BIT = 6;
  localparam int RESV_BIT = 7;
  localparam logic [6:0] WRITE_MASK = 7'h7F; // writable bits below the reserved one
  // ecr mode codes
  localparam logic [2:0] ECR_SPP = 3'h0;
  localparam logic [2:0] ECR_EPP = 3'h4;
  // floppy routing codes
  localparam logic [1:0] FLOPPY_NORMAL = 2'h0;
  localparam logic [1:0] FLOPPY_RESERVED = 2'h3;
  // baud divisors
  localparam logic [3:0] DIV_NORMAL = 4'hD; // divide by 13
  localparam logic [3:0] DIV_MIDI = 4'hC; // divide by 12
  localparam logic [3:0] REF_LAST = 4'hF; // second stage divides by 16

  // parallel port base mode, one-hot
  typedef enum logic [3:0] {
    PM_SPP = 4'b0001,
    PM_EPP = 4'b0010,
    PM_ECP = 4'b0100,
    PM_ECP_EPP = 4'b1000
  } psx_mode_type;

  // two-bit mode code to base mode
  function automatic psx_mode_type psx_decode_mode(input logic [1:0] code);
    unique case (code)
      2'h0: psx_decode_mode = PM_SPP;
      2'h1: psx_decode_mode = PM_EPP;
      2'h2: psx_decode_mode = PM_ECP;
      2'h3: psx_decode_mode = PM_ECP_EPP;
    endcase
  endfunction : psx_decode_mode
endpackage : psx_pkg

// ==== rtl/psx_setup.sv ====
/*
  parallel and serial extended setup register with its mode decode and
  the two uart baud pre-dividers.
  assumes the config mode flag, the index register value, the override
  bit, the other register's mode and the ecr mode all come from logic on
  this clock; host strobes are one-cycle pulses on this clock.
*/
`timescale 1ns/1ps
module psx_setup (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic configMode,
  input wire logic [7:0] configIndex,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] wrData,
  input wire logic modeOverride,
  input wire logic [1:0] firstCfgMode,
  input wire logic [2:0] ecrMode,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [7:0] setupValue,
  output logic sppActive,
  output logic eppActive,
  output logic ecpActive,
  output psx_pkg::psx_mode_type baseMode,
  output logic eppRev17,
  output logic [1:0] floppyRoute,
  output logic floppyRouteReserved,
  output logic twoDriveLimit,
  output logic uart1BaseTick,
  output logic uart1RefTick,
  output logic uart2BaseTick,
  output logic uart2RefTick
);
  import psx_pkg::*;

  logic [7:0] setup_reg, setup_next; // the register itself
  // read answer: data is zero whenever no read is being answered,
  // so the host side can OR several register answers together
  logic [7:0] rdData_reg, rdData_next;
  logic rdValid_reg, rdValid_next;
  psx_mode_type mode_reg, mode_next; // effective base mode
  logic spp_reg, spp_next;
  logic epp_reg, epp_next;
  logic ecp_reg, ecp_next;
  logic eppRev_reg, eppRev_next;
  logic [1:0] floppy_reg, floppy_next;
  logic floppyRes_reg, floppyRes_next;
  logic twoDrv_reg, twoDrv_next;
  logic selected; // index and mode both point here

  // register access path
  always_comb begin
    selected = configMode && (configIndex == SETUP_INDEX);
    setup_next = setup_reg;
    rdData_next = 8'h00;
    rdValid_next = 1'b0;
    if (selected && wrStrobe) begin
      // reserved bit forced low whatever software writes
      setup_next = {1'b0, wrData[6:0] & WRITE_MASK};
    end
    if (selected && rdStrobe) begin
      // old contents answer even when a write lands in the same cycle
      rdData_next = setup_reg;
      rdValid_next = 1'b1;
    end
  end

  // mode decode; registered so every output is a flop
  always_comb begin
    // override hands the mode to the other register
    if (modeOverride) begin
      mode_next = psx_decode_mode(firstCfgMode);
    end else begin
      mode_next = psx_decode_mode(setup_reg[MODE_LSB +: 2]);
    end
    spp_next = 1'b0;
    epp_next = 1'b0;
    ecp_next = 1'b0;
    unique case (mode_next)
      PM_SPP: begin
        spp_next = 1'b1;
      end
      PM_EPP: begin
        // EPP also keeps standard port access
        epp_next = 1'b1;
        spp_next = 1'b1;
      end
      PM_ECP: begin
        spp_next = (ecrMode == ECR_SPP);
        ecp_next = (ecrMode != ECR_SPP);
      end
      PM_ECP_EPP: begin
        spp_next = (ecrMode == ECR_SPP);
        epp_next = (ecrMode == ECR_EPP);
        ecp_next = (ecrMode != ECR_SPP) && (ecrMode != ECR_EPP);
      end
    endcase
    // ECP modes cannot drive more than two drives directly
    twoDrv_next = (mode_next == PM_ECP) || (mode_next == PM_ECP_EPP);
    eppRev_next = setup_reg[EPPTYPE_BIT];
    // reserved routing code falls back to normal operation
    floppyRes_next = (setup_reg[FLOPPY_LSB +: 2] == FLOPPY_RESERVED);
    floppy_next = floppyRes_next ? FLOPPY_NORMAL : setup_reg[FLOPPY_LSB +: 2];
  end

  // registers only
  // decode flops come out of reset in standard mode, matching a cleared field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup_reg <= SETUP_RESET;
      rdData_reg <= 8'h00;
      rdValid_reg <= 1'b0;
      mode_reg <= PM_SPP;
      spp_reg <= 1'b1;
      epp_reg <= 1'b0;
      ecp_reg <= 1'b0;
      eppRev_reg <= 1'b0;
      floppy_reg <= FLOPPY_NORMAL;
      floppyRes_reg <= 1'b0;
      twoDrv_reg <= 1'b0;
    end else begin
      setup_reg <= setup_next;
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
      mode_reg <= mode_next;
      spp_reg <= spp_next;
      epp_reg <= epp_next;
      ecp_reg <= ecp_next;
      eppRev_reg <= eppRev_next;
      floppy_reg <= floppy_next;
      floppyRes_reg <= floppyRes_next;
      twoDrv_reg <= twoDrv_next;
    end
  end

  // baud pre-dividers, one per uart
  // a midi bit change reaches the divider at once and already sets where its current period wraps
  psx_div_if uart1If ();
  psx_div_if uart2If ();
  assign uart1If.divideBy12 = setup_reg[MIDI1_BIT];
  assign uart2If.divideBy12 = setup_reg[MIDI2_BIT];
  psx_baud_div uart1Div (
    .clk(clk),
    .sys_rst(sys_rst),
    .port(uart1If.div)
  );
  psx_baud_div uart2Div (
    .clk(clk),
    .sys_rst(sys_rst),
    .port(uart2If.div)
  );

  assign rdData = rdData_reg;
  assign rdValid = rdValid_reg;
  assign setupValue = setup_reg;
  assign sppActive = spp_reg;
  assign eppActive = epp_reg;
  assign ecpActive = ecp_reg;
  assign baseMode = mode_reg;
  assign eppRev17 = eppRev_reg;
  assign floppyRoute = floppy_reg;
  assign floppyRouteReserved = floppyRes_reg;
  assign twoDriveLimit = twoDrv_reg;
  assign uart1BaseTick = uart1If.baseTick;
  assign uart1RefTick = uart1If.refTick;
  assign uart2BaseTick = uart2If.baseTick;
  assign uart2RefTick = uart2If.refTick;

  // checks on the register and decode
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // register access checks
  AST_RESERVED_ZERO: assert property (!setup_reg[RESV_BIT] && !(rdValid_reg && rdData_reg[RESV_BIT]))
    else $error("reserved bit seen high");
  // reset is watched from its own edge; the default disable would hide it
  AST_RESET_VALUE: assert property (disable iff (1'b0) sys_rst |=>
    setup_reg == SETUP_RESET && !rdValid_reg && mode_reg == PM_SPP && spp_reg)
    else $error("register not 00H after reset");
  AST_WRITE_GATED: assert property (wrStrobe && !selected |=> $stable(setup_reg))
    else $error("write taken outside config mode or index");
  AST_WRITE_TAKEN: assert property (wrStrobe && selected |=> setup_reg == {1'b0, $past(wrData[6:0])})
    else $error("selected write not stored");
  AST_READ_GATED: assert property (rdStrobe && !selected |=> !rdValid_reg && rdData_reg == 8'h00)
    else $error("read answered outside config mode or index");
  AST_READ_DATA: assert property (rdStrobe && selected |=> rdValid_reg && rdData_reg == $past(setup_reg))
    else $error("selected read did not return the register");
  // decode checks; every decoded flop lags its inputs by one cycle
  AST_DEFAULT_SPP: assert property (!modeOverride && setup_reg[1:0] == 2'h0 |=>
    spp_reg && !epp_reg && !ecp_reg && mode_reg == PM_SPP)
    else $error("field 00 not standard mode");
  AST_EPP_FIELD: assert property (!modeOverride && setup_reg[1:0] == 2'h1 |=> epp_reg && spp_reg && !ecp_reg)
    else $error("field 01 not EPP plus standard");
  AST_ECR_EPP: assert property (!modeOverride && setup_reg[1:0] == 2'h3 && ecrMode == ECR_EPP |=>
    epp_reg && !ecp_reg)
    else $error("ecr 100 did not give EPP");
  AST_ECR_SPP: assert property (!modeOverride && setup_reg[1] && ecrMode == ECR_SPP |=>
    spp_reg && !ecp_reg && twoDrv_reg)
    else $error("ecr 000 did not give standard port");
  AST_DRIVE_LIMIT: assert property (ecp_reg |-> twoDrv_reg)
    else $error("ECP active without two-drive limit");
  AST_NO_LIMIT: assert property (!modeOverride && !setup_reg[1] |=> !twoDrv_reg)
    else $error("two-drive limit outside ECP modes");
  AST_ECP_FIELD: assert property (!modeOverride && setup_reg[1:0] == 2'h2 && ecrMode != ECR_SPP |=>
    ecp_reg && !spp_reg && !epp_reg)
    else $error("field 10 not ECP");
  // override, floppy and EPP revision checks
  AST_OVERRIDE: assert property (modeOverride |=> mode_reg == psx_decode_mode($past(firstCfgMode)))
    else $error("override did not follow other register");
  AST_FLOPPY: assert property (##1 floppyRes_reg == ($past(setup_reg[3:2]) == 2'h3) &&
    (floppyRes_reg || floppy_reg == $past(setup_reg[3:2])))
    else $error("floppy routing decode wrong");
  AST_EPP_REV: assert property (##1 eppRev17 == $past(setup_reg[EPPTYPE_BIT]))
    else $error("EPP revision does not follow bit 6");

  // main scenarios worth seeing
  COV_WRITE: cover property (wrStrobe && selected);
  COV_ECP_EPP: cover property (!modeOverride && setup_reg[1:0] == 2'h3 && ecrMode == ECR_EPP);
  COV_READBACK: cover property (wrStrobe && selected ##[1:4] rdValid_reg);
  COV_OVERRIDE: cover property (modeOverride && setup_reg[1:0] != firstCfgMode);
endmodule : psx_setup

// ==== testbench/psx_setup_tb.sv ====
/*
  self-checking bench for the setup register: access, mode and floppy decode,
  ecr overrides and both baud pre-dividers.
  assumes the rtl package, interface and modules are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin failCount++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module psx_setup_tb;
  import psx_pkg::*;
  logic clk = 1'b0; // device clock
  logic sys_rst = 1'b1; // held for three cycles
  logic configMode = 1'b0; // host in config mode
  logic [7:0] configIndex = 8'h00; // index register value
  logic wrStrobe = 1'b0; // host write pulse
  logic rdStrobe = 1'b0; // host read pulse
  logic [7:0] wrData = 8'h00; // write byte
  logic modeOverride = 1'b0; // other register's override bit
  logic [1:0] firstCfgMode = 2'h0; // other register's mode
  logic [2:0] ecrMode = 3'h1; // neutral ecr code
  logic [7:0] rdData, setupValue;
  logic rdValid, sppActive, eppActive, ecpActive, eppRev17, floppyRouteReserved, twoDriveLimit;
  logic [1:0] floppyRoute;
  logic uart1BaseTick, uart1RefTick, uart2BaseTick, uart2RefTick;
  psx_mode_type baseMode;
  psx_mode_type modeTbl [4] = '{PM_SPP, PM_EPP, PM_ECP, PM_ECP_EPP}; // expected per code
  int failCount = 0;
  int compares = 0;
  int cycles = 0; // timeout counter

  psx_setup psx_setup_inst (.clk(clk), .sys_rst(sys_rst), .configMode(configMode),
    .configIndex(configIndex), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData),
    .modeOverride(modeOverride), .firstCfgMode(firstCfgMode), .ecrMode(ecrMode),
    .rdData(rdData), .rdValid(rdValid), .setupValue(setupValue), .sppActive(sppActive),
    .eppActive(eppActive), .ecpActive(ecpActive), .baseMode(baseMode), .eppRev17(eppRev17),
    .floppyRoute(floppyRoute), .floppyRouteReserved(floppyRouteReserved),
    .twoDriveLimit(twoDriveLimit), .uart1BaseTick(uart1BaseTick), .uart1RefTick(uart1RefTick),
    .uart2BaseTick(uart2BaseTick), .uart2RefTick(uart2RefTick));

  // free-running clock, 5 ns period
  always #2.5 clk = ~clk;

  // hang guard: whole run needs well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    if (failCount == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : endOfTest

  // one host write, returns once decoded outputs have followed
  task automatic wr(input logic [7:0] v, input logic cm, input logic [7:0] idx);
    @(posedge clk);
    configMode <= cm;
    configIndex <= idx;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : wr

  // one selected read, answer expected in the next cycle only
  task automatic rdChk(input logic [7:0] ex);
    @(posedge clk);
    configMode <= 1'b1;
    configIndex <= SETUP_INDEX;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    @(negedge clk);
    `CHK("rdValid", 1'b1, rdValid)
    `CHK("rdData", ex, rdData)
    @(negedge clk);
    `CHK("rdValid end", 1'b0, rdValid)
  endtask : rdChk

  // side inputs from the other registers
  task automatic setIn(input logic ov, input logic [1:0] fm, input logic [2:0] ecr);
    @(posedge clk);
    modeOverride <= ov;
    firstCfgMode <= fm;
    ecrMode <= ecr;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
  endtask : setIn

  task automatic flags(input logic s, input logic e, input logic c);
    `CHK("sppActive", s, sppActive)
    `CHK("eppActive", e, eppActive)
    `CHK("ecpActive", c, ecpActive)
  endtask : flags

  task automatic testAccess();
    `CHK("reset value", SETUP_RESET, setupValue)
    `CHK("reset mode", PM_SPP, baseMode)
    `CHK("reset rev", 1'b0, eppRev17)
    rdChk(8'h00);
    wr(8'hFF, 1'b1, SETUP_INDEX);
    `CHK("top bit", 8'h7F, setupValue)
    rdChk(8'h7F);
    wr(8'h00, 1'b0, SETUP_INDEX); // outside config mode
    wr(8'h00, 1'b1, 8'h05); // wrong index
    `CHK("refused write", 8'h7F, setupValue)
    @(posedge clk);
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    @(negedge clk);
    `CHK("refused read", 1'b0, rdValid)
  endtask : testAccess

  task automatic testMode();
    setIn(1'b0, 2'h0, 3'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'(i), 1'b1, SETUP_INDEX);
      `CHK("baseMode", modeTbl[i], baseMode)
      flags(i < 2, i == 1, i >= 2);
      `CHK("twoDriveLimit", i >= 2, twoDriveLimit)
    end
    setIn(1'b0, 2'h0, ECR_EPP);
    flags(1'b0, 1'b1, 1'b0);
    setIn(1'b0, 2'h0, ECR_SPP);
    flags(1'b1, 1'b0, 1'b0);
    wr(8'h02, 1'b1, SETUP_INDEX);
    setIn(1'b0, 2'h0, ECR_EPP);
    flags(1'b0, 1'b0, 1'b1);
    setIn(1'b1, 2'h1, 3'h1);
    `CHK("override", PM_EPP, baseMode)
    `CHK("override limit", 1'b0, twoDriveLimit)
    setIn(1'b1, 2'h3, ECR_EPP);
    `CHK("override combined", PM_ECP_EPP, baseMode)
    flags(1'b0, 1'b1, 1'b0);
    setIn(1'b0, 2'h0, 3'h1);
  endtask : testMode

  task automatic testFloppy();
    for (int i = 0; i < 4; i++) begin
      wr(8'(i << 2), 1'b1, SETUP_INDEX);
      `CHK("floppyRoute", (i == 3) ? 2'h0 : 2'(i), floppyRoute)
      `CHK("floppy reserved", i == 3, floppyRouteReserved)
    end
    wr(8'h40, 1'b1, SETUP_INDEX);
    `CHK("eppRev17", 1'b1, eppRev17)
  endtask : testFloppy

  function automatic logic tick(input int u, input logic isRef);
    if (u == 1) begin
      return isRef ? uart1RefTick : uart1BaseTick;
    end
    return isRef ? uart2RefTick : uart2BaseTick;
  endfunction : tick

  // one reference period: sixteen base ticks of div cycles each
  task automatic meas(input int u, input int div);
    int c;
    int b;
    c = 0;
    b = 0;
    for (int k = 0; k < 2; k++) begin
      do @(negedge clk); while (tick(u, k == 1) !== 1'b1 && ++c < 600);
    end
    c = 0;
    do begin
      @(negedge clk);
      c++;
      if (tick(u, 1'b0) === 1'b1) b++;
    end while (tick(u, 1'b1) !== 1'b1 && c < 600);
    `CHK("ref period", 16 * div, c)
    `CHK("base per ref", 16, b)
  endtask : meas

  task automatic testDiv();
    wr(8'h00, 1'b1, SETUP_INDEX);
    meas(1, 13);
    meas(2, 13);
    wr(8'h10, 1'b1, SETUP_INDEX);
    meas(1, 12);
    meas(2, 13);
    wr(8'h20, 1'b1, SETUP_INDEX);
    meas(1, 13);
    meas(2, 12);
  endtask : testDiv

  // second reset in mid-run clears the register again
  task automatic testReset();
    wr(8'h55, 1'b1, SETUP_INDEX);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK("rerun value", SETUP_RESET, setupValue)
    `CHK("rerun mode", PM_SPP, baseMode)
    @(posedge clk);
    // release with a write already standing, taken at the first edge out of reset
    sys_rst <= 1'b0;
    wrData <= 8'h01;
    wrStrobe <= 1'b1;
    @(negedge clk);
    `CHK("rerun rdValid", 1'b0, rdValid)
    `CHK("rerun spp", 1'b1, sppActive)
    @(posedge clk);
    wrStrobe <= 1'b0;
    @(negedge clk);
    `CHK("first write", 8'h01, setupValue)
    @(negedge clk);
    `CHK("first write mode", PM_EPP, baseMode)
    meas(1, 13);
  endtask : testReset

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    testAccess();
    testMode();
    testFloppy();
    testDiv();
    testReset();
    endOfTest();
  end
endmodule : psx_setup_tb
